// >>> design/plb_pkg.sv
// constants shared by the pin control, loopback and status block
package plb_pkg;
    localparam int PIN_W = 10;
    // register offsets
    localparam logic [7:0] ADR_CINT = 8'h12;
    localparam logic [7:0] ADR_OD   = 8'h13;
    localparam logic [7:0] ADR_PU   = 8'h14;
    localparam logic [7:0] ADR_PD   = 8'h15;
    localparam logic [7:0] ADR_LB   = 8'h16;
    // writable bits and reset values
    localparam logic [15:0] MSK_CINT = 16'h0003;
    localparam logic [15:0] MSK_OD   = 16'h0BFF;
    localparam logic [15:0] MSK_PULL = 16'h07FF;
    localparam logic [15:0] MSK_LB   = 16'h0007;
    localparam logic [15:0] RST_OD   = 16'h0080;
    localparam logic [15:0] RST_PU   = 16'h07FF;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    // field positions
    localparam int OD_TX    = 11;
    localparam int LB_DATA  = 0;
    localparam int LB_RTS   = 1;
    localparam int LB_DTR   = 2;
    localparam int CINT_CUS = 0;
    localparam int CINT_BRK = 1;
    localparam int STD_OVR  = 6;
    localparam int STD_PAR  = 5;
    localparam int STD_FRM  = 4;
    localparam int STD_RI   = 3;
    localparam int STD_BRK  = 2;
    localparam int STD_DSR  = 1;
    localparam int STD_DCD  = 0;
    localparam int CST_OVR  = 3;
    localparam int CST_PAR  = 2;
    localparam int CST_FRM  = 1;
    localparam int CST_BRK  = 0;
    // packet bytes and lengths
    localparam logic [7:0] PK_REQTYPE = 8'hA1;
    localparam logic [7:0] PK_NOTIF   = 8'h20;
    localparam logic [7:0] PK_WLEN    = 8'h02;
    localparam logic [7:0] PK_ZERO    = 8'h00;
    localparam logic [3:0] STD_LAST   = 4'h9;
    localparam logic [3:0] CUS_LAST   = 4'h4;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } plb_fsm_type;
endpackage : plb_pkg

// >>> design/plb_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module plb_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } plb_sync_type;

    plb_sync_type r_q;
    plb_sync_type r_d;

    // first stage feeds only the second
    always_comb begin
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    // registers, cleared at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;
endmodule : plb_sync
`default_nettype wire

// >>> design/plb_top.sv
// pin control registers, uart loopback and interrupt status packet builder
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module plb_top (
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic        CORE_TXD,
    input  wire logic        CORE_RTS_N,
    input  wire logic        CORE_DTR_N,
    output logic             CORE_RXD,
    output logic             CORE_CTS_N,
    output logic             CORE_DSR_N,
    input  wire logic        ERR_OVERRUN,
    input  wire logic        ERR_PARITY,
    input  wire logic        ERR_FRAMING,
    input  wire logic        BREAK_STATE,
    input  wire logic        PIN_RXD,
    input  wire logic        PIN_CTS_N,
    input  wire logic        PIN_DSR_N,
    input  wire logic        PIN_DCD_N,
    input  wire logic        PIN_RI_N,
    input  wire logic [9:0]  PIN_GPIO,
    input  wire logic [9:0]  GPIO_OUT,
    input  wire logic [9:0]  GPIO_OUT_EN,
    output logic             TXD_O,
    output logic             TXD_OE,
    output logic      [9:0]  GPIO_O,
    output logic      [9:0]  GPIO_OE,
    output logic      [10:0] PULLUP_EN,
    output logic      [10:0] PULLDOWN_EN,
    input  wire logic        PKT_REQ,
    output logic             PKT_PENDING,
    output logic      [7:0]  PKT_DATA,
    output logic             PKT_VALID,
    output logic             PKT_LAST
);
    localparam int SW = plb_pkg::PIN_W + 5;
    // serial and modem pins idle high: held inverted so a cleared synchroniser
    // shows idle, and no false start bit or modem edge follows reset
    localparam logic [SW-1:0] IDLE_HI = {{plb_pkg::PIN_W{1'b0}}, 5'h1F};

    typedef struct packed {
        plb_pkg::plb_fsm_type fsm;
        logic [3:0]  idx;
        logic        cust;
        logic [15:0] s_std;
        logic [9:0]  s_gpio;
        logic [9:0]  s_chg;
        logic [7:0]  s_cst;
        logic [15:0] od;
        logic [15:0] pu;
        logic [15:0] pd;
        logic [15:0] lb;
        logic [15:0] cint;
        logic [15:0] rdata;
        logic [9:0]  prev;
        logic [9:0]  chg;
        logic [15:0] prev_std;
        logic        pend;
        logic [7:0]  pdata;
        logic        pvalid;
        logic        plast;
        logic        txd_o;
        logic        txd_oe;
        logic [9:0]  gpio_o;
        logic [9:0]  gpio_oe;
        logic        rxd;
        logic        cts_n;
        logic        dsr_n;
        logic [10:0] pd_eff;
    } plb_regs_type;

    plb_regs_type q;
    plb_regs_type d;
    logic [SW-1:0] pins;
    logic [9:0]    gpio_s;
    logic          rxd_s;
    logic          cts_s;
    logic          dsr_s;
    logic          dcd_s;
    logic          ri_s;
    logic [15:0]   std_now;
    logic [7:0]    cst_now;
    logic [9:0]    new_chg;
    logic [7:0]    pbyte;

    // every pin input passes two flops first
    plb_sync #(
        .W (SW)
    ) u_sync (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .d     ({PIN_GPIO, PIN_RXD, PIN_CTS_N, PIN_DSR_N, PIN_DCD_N, PIN_RI_N} ^ IDLE_HI),
        .q     (pins)
    );
    assign {gpio_s, rxd_s, cts_s, dsr_s, dcd_s, ri_s} = pins ^ IDLE_HI;

    // live status words in both layouts
    always_comb begin
        std_now = 16'h0000;
        std_now[plb_pkg::STD_OVR] = ERR_OVERRUN;
        std_now[plb_pkg::STD_PAR] = ERR_PARITY;
        std_now[plb_pkg::STD_FRM] = ERR_FRAMING;
        std_now[plb_pkg::STD_RI]  = ~ri_s;
        std_now[plb_pkg::STD_BRK] = BREAK_STATE;
        std_now[plb_pkg::STD_DSR] = ~q.dsr_n;
        std_now[plb_pkg::STD_DCD] = ~dcd_s;
        cst_now = 8'h00;
        cst_now[plb_pkg::CST_OVR] = ERR_OVERRUN;
        cst_now[plb_pkg::CST_PAR] = ERR_PARITY;
        cst_now[plb_pkg::CST_FRM] = ERR_FRAMING;
        cst_now[plb_pkg::CST_BRK] = BREAK_STATE;
        new_chg = gpio_s ^ q.prev;
    end

    // packet byte at the current index
    always_comb begin
        pbyte = plb_pkg::PK_ZERO;
        if (q.cust) begin
            case (q.idx)
                4'h0: pbyte = q.s_gpio[7:0];
                4'h1: pbyte = {6'h00, q.s_gpio[9:8]};
                4'h2: pbyte = q.s_chg[7:0];
                4'h3: pbyte = {6'h00, q.s_chg[9:8]};
                4'h4: pbyte = q.s_cst;
                default: pbyte = plb_pkg::PK_ZERO;
            endcase
        end else begin
            case (q.idx)
                4'h0: pbyte = plb_pkg::PK_REQTYPE;
                4'h1: pbyte = plb_pkg::PK_NOTIF;
                4'h6: pbyte = plb_pkg::PK_WLEN;
                4'h8: pbyte = q.s_std[7:0];
                4'h9: pbyte = q.s_std[15:8];
                default: pbyte = plb_pkg::PK_ZERO;
            endcase
        end
    end

    // next state of registers, pins and packet engine
    always_comb begin
        d = q;
        // register writes keep reserved bits at zero
        if (WR) begin
            case (ADDR)
                plb_pkg::ADR_CINT: d.cint = WDATA & plb_pkg::MSK_CINT;
                plb_pkg::ADR_OD:   d.od   = WDATA & plb_pkg::MSK_OD;
                plb_pkg::ADR_PU:   d.pu   = WDATA & plb_pkg::MSK_PULL;
                plb_pkg::ADR_PD:   d.pd   = WDATA & plb_pkg::MSK_PULL;
                plb_pkg::ADR_LB:   d.lb   = WDATA & plb_pkg::MSK_LB;
                default: d.cint = q.cint;
            endcase
        end
        // register reads, answered next cycle
        d.rdata = 16'h0000;
        if (RD) begin
            case (ADDR)
                plb_pkg::ADR_CINT: d.rdata = q.cint;
                plb_pkg::ADR_OD:   d.rdata = q.od;
                plb_pkg::ADR_PU:   d.rdata = q.pu;
                plb_pkg::ADR_PD:   d.rdata = q.pd;
                plb_pkg::ADR_LB:   d.rdata = q.lb;
                default: d.rdata = 16'h0000;
            endcase
        end
        // transmit pin: push-pull or open-drain, released in loopback
        if (q.lb[plb_pkg::LB_DATA]) begin
            d.txd_o  = 1'b0;
            d.txd_oe = 1'b0;
        end else if (q.od[plb_pkg::OD_TX]) begin
            d.txd_o  = 1'b0;
            d.txd_oe = ~CORE_TXD;
        end else begin
            d.txd_o  = CORE_TXD;
            d.txd_oe = 1'b1;
        end
        // output pins, whatever function drives them
        d.gpio_o  = GPIO_OUT & ~q.od[9:0];
        d.gpio_oe = GPIO_OUT_EN & ~(q.od[9:0] & GPIO_OUT);
        // pull-up wins over pull-down, from the values that take effect together
        d.pd_eff = d.pd[10:0] & ~d.pu[10:0];
        // internal loopback paths
        d.rxd   = q.lb[plb_pkg::LB_DATA] ? CORE_TXD : rxd_s;
        d.cts_n = q.lb[plb_pkg::LB_RTS] ? CORE_RTS_N : cts_s;
        d.dsr_n = q.lb[plb_pkg::LB_DTR] ? CORE_DTR_N : dsr_s;
        // change flags and pending packet; a set beats the clear
        d.prev     = gpio_s;
        d.prev_std = std_now;
        if (PKT_REQ && q.fsm == plb_pkg::ST_IDLE) begin
            d.chg  = new_chg;
            d.pend = 1'b0;
        end else begin
            d.chg = q.chg | new_chg;
        end
        if ((|new_chg) || (std_now != q.prev_std)
            || (BREAK_STATE && !q.prev_std[plb_pkg::STD_BRK] && q.cint[plb_pkg::CINT_BRK])) begin
            d.pend = 1'b1;
        end
        // packet engine
        d.pvalid = 1'b0;
        d.plast  = 1'b0;
        case (q.fsm)
            plb_pkg::ST_IDLE: begin
                if (PKT_REQ) begin
                    d.fsm    = plb_pkg::ST_SEND;
                    d.idx    = 4'h0;
                    d.cust   = q.cint[plb_pkg::CINT_CUS];
                    d.s_std  = std_now;
                    d.s_gpio = gpio_s;
                    d.s_chg  = q.chg | new_chg;
                    d.s_cst  = cst_now;
                end
            end
            plb_pkg::ST_SEND: begin
                d.pvalid = 1'b1;
                d.pdata  = pbyte;
                d.plast  = q.idx == (q.cust ? plb_pkg::CUS_LAST : plb_pkg::STD_LAST);
                if (d.plast) begin
                    d.fsm = plb_pkg::ST_IDLE;
                end else begin
                    d.idx = q.idx + 4'h1;
                end
            end
            default: d.fsm = plb_pkg::ST_IDLE;
        endcase
    end

    // state register with documented reset values
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            q        <= '0;
            q.fsm    <= plb_pkg::ST_IDLE;
            q.od     <= plb_pkg::RST_OD;
            q.pu     <= plb_pkg::RST_PU;
            q.pd     <= plb_pkg::RST_ZERO;
            q.lb     <= plb_pkg::RST_ZERO;
            q.rxd    <= 1'b1;
            q.cts_n  <= 1'b1;
            q.dsr_n  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign RDATA       = q.rdata;
    assign CORE_RXD    = q.rxd;
    assign CORE_CTS_N  = q.cts_n;
    assign CORE_DSR_N  = q.dsr_n;
    assign TXD_O       = q.txd_o;
    assign TXD_OE      = q.txd_oe;
    assign GPIO_O      = q.gpio_o;
    assign GPIO_OE     = q.gpio_oe;
    assign PULLUP_EN   = q.pu[10:0];
    assign PULLDOWN_EN = q.pd_eff;
    assign PKT_PENDING = q.pend;
    assign PKT_DATA    = q.pdata;
    assign PKT_VALID   = q.pvalid;
    assign PKT_LAST    = q.plast;

    // checks on the driven outputs
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    property p_pull_excl;
        ##1 (PULLDOWN_EN & PULLUP_EN) == 11'h000;
    endproperty
    a_pull_excl: assert property (p_pull_excl)
        else $error("pull-up and pull-down both active");

    property p_tx_release;
        q.lb[plb_pkg::LB_DATA] |=> !TXD_OE;
    endproperty
    a_tx_release: assert property (p_tx_release)
        else $error("transmit pin driven during loopback");

    property p_data_loop;
        q.lb[plb_pkg::LB_DATA] && !WR |=> CORE_RXD == $past(CORE_TXD);
    endproperty
    a_data_loop: assert property (p_data_loop)
        else $error("receiver not fed from transmitter");

    property p_rts_loop;
        q.lb[plb_pkg::LB_RTS] |=> CORE_CTS_N == $past(CORE_RTS_N);
    endproperty
    a_rts_loop: assert property (p_rts_loop)
        else $error("clear-to-send not looped");

    property p_dtr_loop;
        q.lb[plb_pkg::LB_DTR] |=> CORE_DSR_N == $past(CORE_DTR_N);
    endproperty
    a_dtr_loop: assert property (p_dtr_loop)
        else $error("set-ready not looped");

    property p_std_pkt;
        $rose(PKT_VALID) && !q.cust |-> PKT_DATA == plb_pkg::PK_REQTYPE ##6
            PKT_DATA == plb_pkg::PK_WLEN ##2 !PKT_DATA[7] ##1
            (PKT_DATA == plb_pkg::PK_ZERO && PKT_LAST) ##1 !PKT_VALID;
    endproperty
    a_std_pkt: assert property (p_std_pkt)
        else $error("standard packet malformed");

    property p_cus_pkt;
        $rose(PKT_VALID) && q.cust |-> ##1 PKT_DATA[7:2] == 6'h00 ##2
            PKT_DATA[7:2] == 6'h00 ##1 (PKT_DATA[7:4] == 4'h0 && PKT_LAST) ##1 !PKT_VALID;
    endproperty
    a_cus_pkt: assert property (p_cus_pkt)
        else $error("custom packet malformed");

    property p_od_gpio;
        ##1 (GPIO_OE & GPIO_O & $past(q.od[9:0])) == 10'h000
            && (GPIO_OE & $past(q.od[9:0]) & $past(GPIO_OUT)) == 10'h000;
    endproperty
    a_od_gpio: assert property (p_od_gpio)
        else $error("open-drain pin driven high");

    property p_rsvd_read;
        RD && ADDR == plb_pkg::ADR_LB |=> RDATA[15:3] == 13'h0000;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved loopback bits read nonzero");

    c_std_pkt: cover property ($rose(PKT_VALID) && !q.cust);
    c_cus_pkt: cover property ($rose(PKT_VALID) && q.cust);
    c_loop:    cover property (q.lb[plb_pkg::LB_DATA] && q.lb[plb_pkg::LB_RTS]);
endmodule : plb_top
`default_nettype wire

// >>> testbench/plb_host_model.sv
// host side model that asks for interrupt status packets and gathers their bytes
`timescale 1ns/1ns
`default_nettype none
module plb_host_model (
    input  wire logic       clk,
    input  wire logic       pkt_valid,
    input  wire logic [7:0] pkt_data,
    input  wire logic       pkt_last,
    output var logic        pkt_req
);
    logic [7:0] pkt [0:15];
    int         count;

    initial pkt_req = 1'b0;

    // one request pulse launched at a rising edge after an optional stall,
    // then bytes are taken until the last one
    task automatic fetch(input int slow);
        int k;
        repeat (slow + 1) @(posedge clk);
        pkt_req <= 1'b1;
        @(posedge clk);
        pkt_req <= 1'b0;
        count = 0;
        for (k = 0; k < 40; k++) begin
            @(negedge clk);
            if (pkt_valid === 1'b1 && count < 16) begin
                pkt[count] = pkt_data;
                count++;
                if (pkt_last === 1'b1) break;
            end
        end
        @(posedge clk);
    endtask : fetch
endmodule : plb_host_model
`default_nettype wire

// >>> testbench/test_plb_top.sv
// self-checking bench for the pin control, loopback and status block
`timescale 1ns/1ns
`default_nettype none
module test_plb_top;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        core_txd = 1'b0;
    logic        core_rts_n = 1'b1;
    logic        core_dtr_n = 1'b1;
    logic        err_ovr = 1'b1;
    logic        err_par = 1'b0;
    logic        err_frm = 1'b1;
    logic        brk = 1'b1;
    logic        pin_rxd = 1'b1;
    logic        pin_cts_n = 1'b1;
    logic        pin_dsr_n = 1'b0;
    logic        pin_dcd_n = 1'b1;
    logic        pin_ri_n = 1'b0;
    logic [9:0]  pin_gpio = 10'h000;
    logic [9:0]  gpio_out = 10'h3C3;
    logic [9:0]  gpio_en = 10'h3FF;
    logic [15:0] rdata;
    logic        core_rxd, core_cts_n, core_dsr_n, txd_o, txd_oe;
    logic [9:0]  gpio_o, gpio_oe;
    logic [10:0] pullup_en, pulldown_en;
    logic        pkt_req, pkt_pending, pkt_valid, pkt_last;
    logic [7:0]  pkt_data;
    int          miscompares = 0;
    int          comparisons = 0;

    always #4 clock = ~clock;

    plb_top i_plb_top (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .CORE_TXD(core_txd), .CORE_RTS_N(core_rts_n),
        .CORE_DTR_N(core_dtr_n), .CORE_RXD(core_rxd), .CORE_CTS_N(core_cts_n),
        .CORE_DSR_N(core_dsr_n), .ERR_OVERRUN(err_ovr), .ERR_PARITY(err_par),
        .ERR_FRAMING(err_frm), .BREAK_STATE(brk), .PIN_RXD(pin_rxd), .PIN_CTS_N(pin_cts_n),
        .PIN_DSR_N(pin_dsr_n), .PIN_DCD_N(pin_dcd_n), .PIN_RI_N(pin_ri_n),
        .PIN_GPIO(pin_gpio), .GPIO_OUT(gpio_out), .GPIO_OUT_EN(gpio_en), .TXD_O(txd_o),
        .TXD_OE(txd_oe), .GPIO_O(gpio_o), .GPIO_OE(gpio_oe), .PULLUP_EN(pullup_en),
        .PULLDOWN_EN(pulldown_en), .PKT_REQ(pkt_req), .PKT_PENDING(pkt_pending),
        .PKT_DATA(pkt_data), .PKT_VALID(pkt_valid), .PKT_LAST(pkt_last));

    plb_host_model i_plb_host_model (.clk(clock), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
        .pkt_last(pkt_last), .pkt_req(pkt_req));

    // compare one value and count it
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask : check

    // register bus cycles, each launched just after a rising edge
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp, input string nm);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        check(nm, exp, rdata);
    endtask : reg_read

    // lets synchronisers and output flops catch up
    task automatic settle;
        repeat (4) @(negedge clock);
    endtask : settle

    // pin drive expected from a driver-type value
    task automatic check_drive(input logic [11:0] od);
        check("gpio_o", 16'(gpio_out & ~od[9:0]), 16'(gpio_o));
        check("gpio_oe", 16'(gpio_en & ~(od[9:0] & gpio_out)), 16'(gpio_oe));
        check("txd_o", od[11] ? 16'h0000 : 16'(core_txd), 16'(txd_o));
        check("txd_oe", od[11] ? {15'h0000, ~core_txd} : 16'h0001, 16'(txd_oe));
    endtask : check_drive

    task automatic t_reset;
        settle();
        reg_read(plb_pkg::ADR_OD, 16'h0080, "od reset");
        reg_read(plb_pkg::ADR_PU, 16'h07FF, "pu reset");
        reg_read(plb_pkg::ADR_PD, 16'h0000, "pd reset");
        reg_read(plb_pkg::ADR_LB, 16'h0000, "lb reset");
        reg_read(8'h20, 16'h0000, "unmapped read");
        check("pullup_en", 16'h07FF, 16'(pullup_en));
        check("pulldown_en", 16'h0000, 16'(pulldown_en));
        check("rxd from pin", 16'(pin_rxd), 16'(core_rxd));
        check_drive(12'h080);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_reserved;
        logic [7:0]  a [0:4] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
        logic [15:0] m [0:4] = '{plb_pkg::MSK_CINT, plb_pkg::MSK_OD, plb_pkg::MSK_PULL,
                                 plb_pkg::MSK_PULL, plb_pkg::MSK_LB};
        logic [15:0] r [0:4] = '{16'h0000, 16'h0080, 16'h07FF, 16'h0000, 16'h0000};
        for (int k = 0; k < 5; k++) begin
            reg_write(a[k], 16'hFFFF);
            reg_read(a[k], m[k], "reserved bits");
            reg_write(a[k], r[k]);
        end
        reg_write(8'h20, 16'hFFFF);
        reg_read(plb_pkg::ADR_OD, 16'h0080, "od after stray write");
        $display("test reserved bits done");
    endtask : t_reserved

    task automatic t_drive;
        reg_write(plb_pkg::ADR_OD, 16'h0AAA);
        @(posedge clock);
        gpio_en <= 10'h2F0;
        settle();
        check_drive(12'hAAA);
        @(posedge clock);
        core_txd <= 1'b1;
        settle();
        check_drive(12'hAAA);
        reg_write(plb_pkg::ADR_OD, 16'h0080);
        $display("test driver type done");
    endtask : t_drive

    task automatic t_pull;
        reg_write(plb_pkg::ADR_PU, 16'h0055);
        reg_write(plb_pkg::ADR_PD, 16'h07FF);
        settle();
        check("pullup_en", 16'h0055, 16'(pullup_en));
        check("pulldown_en", 16'h07FF & ~16'h0055, 16'(pulldown_en));
        reg_read(plb_pkg::ADR_PD, 16'h07FF, "pd readback");
        $display("test pulls done");
    endtask : t_pull

    task automatic t_loop;
        reg_write(plb_pkg::ADR_LB, 16'h0007);
        @(posedge clock);
        pin_rxd    <= 1'b0;
        core_rts_n <= 1'b0;
        core_dtr_n <= 1'b0;
        pin_dsr_n  <= 1'b1;
        settle();
        check("rxd loop", 16'h0001, 16'(core_rxd));
        check("txd_oe loop", 16'h0000, 16'(txd_oe));
        check("cts loop", 16'h0000, 16'(core_cts_n));
        check("dsr loop", 16'h0000, 16'(core_dsr_n));
        reg_write(plb_pkg::ADR_LB, 16'h0000);
        settle();
        check("rxd pin", 16'h0000, 16'(core_rxd));
        check("cts pin", 16'h0001, 16'(core_cts_n));
        check("dsr pin", 16'h0001, 16'(core_dsr_n));
        @(posedge clock);
        pin_dsr_n <= 1'b0;
        settle();
        $display("test loopback done");
    endtask : t_loop

    task automatic t_std;
        logic [7:0] e [0:9] = '{8'hA1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00,
                                8'h5E, 8'h00};
        i_plb_host_model.fetch(0);
        check("std count", 16'h000A, 16'(i_plb_host_model.count));
        for (int k = 0; k < 10; k++) begin
            check("std byte", 16'(e[k]), 16'(i_plb_host_model.pkt[k]));
        end
        $display("test standard packet done");
    endtask : t_std

    task automatic t_cus;
        logic [7:0] e [0:4] = '{8'hC5, 8'h02, 8'hC5, 8'h02, 8'h0B};
        reg_write(plb_pkg::ADR_CINT, 16'h0001);
        i_plb_host_model.fetch(5);
        @(negedge clock);
        check("pending clear", 16'h0000, 16'(pkt_pending));
        @(posedge clock);
        pin_gpio <= 10'h2C5;
        settle();
        check("pending", 16'h0001, 16'(pkt_pending));
        i_plb_host_model.fetch(0);
        check("cus count", 16'h0005, 16'(i_plb_host_model.count));
        for (int k = 0; k < 5; k++) begin
            check("cus byte", 16'(e[k]), 16'(i_plb_host_model.pkt[k]));
        end
        $display("test custom packet done");
    endtask : t_cus

    // prints counts and verdict, then stops
    task automatic close_out;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_reserved();
        t_drive();
        t_pull();
        t_loop();
        t_std();
        t_cus();
        close_out();
    end

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        $display("watchdog expired");
        close_out();
    end
endmodule : test_plb_top
`default_nettype wire
